/* File: src/pav_consts.vh */
// Constants for the picture adjust and blanking control stage.
// Assumes inclusion by bare name from the design file only.
`ifndef PAV_CONSTS_VH
`define PAV_CONSTS_VH
`define PAV_ADDR_STD 12'h000
`define PAV_ADDR_LGAIN 12'h004
`define PAV_ADDR_LOFS 12'h008
`define PAV_ADDR_CROT 12'h00C
`define PAV_ADDR_CGAIN 12'h010
`define PAV_ADDR_BLANK 12'h014
`define PAV_ADDR_STAT 12'h018
`define PAV_RST_STD 8'h00
`define PAV_RST_LGAIN 8'h80
`define PAV_RST_LOFS 8'h00
`define PAV_RST_CROT 8'h00
`define PAV_RST_CGAIN 8'h80
`define PAV_RST_BLANK 8'h14
`define PAV_BIT_MONO 5
`define PAV_BIT_SETUP 4
`define PAV_BIT_AUX 6
`define PAV_BIT_PASS 7
`define PAV_BIT_VSEL 6
`define PAV_BIT_HALF 5
`define PAV_BLACK_Y 10'h040
`define PAV_MID_C 10'h200
`define PAV_MAX10 10'h3FF
`define PAV_SETUP_OFS 10'h02A
`define PAV_HALF_PIX 10'h1AD
`define PAV_STD_625 4'h8
`define PAV_STD_COMP 4'h4
`endif

/* File: src/pav_picture_adjust.v */
// Luma/chroma picture adjust and blanking interval control, with APB registers.
// Assumes samples, line number and pixel index arrive synchronous to pclk.
// How it works
// - Monochrome bit forces chroma outputs to midscale; luma passes through the normal path.
// - Monochrome forcing applies for every input source and line system.
// - Luma multiplied by 8-bit gain, 0x80 is unity, range zero to two.
// - All gain and offset arithmetic on 22-bit signed values, saturating to 0 and 1023.
// - Signed luma offset -128..127 added, reset zero.
// - Offset added in raw code steps, not scaled for sync level or setup; caller calibrates.
// - Chroma rotated by signed hue value, about 0.45 degree per step.
// - Rotation bypassed for component sources and for the 625-line standard.
// - Chroma multiplied by 8-bit gain, 0x80 unity.
// - Blanking length is 5-bit field, reset 20 lines.
// - Blanking lines output black luma and midscale chroma by default.
// - Passthrough bit sends raw input luma on blanking lines.
// - No setup processing inside the blanking interval.
// - Half-line bit limits setup to latter half of second-field first active line.
// - V-bit timing select chooses one of two fixed 525-line tables.
// - 525-line V-bit low on 10-263,273-525 or 20-263,283-525.
// - 625-line V-bit high on 1-22, 311-335, 624-625.
// - Second-field blanking from 264 to length+245, or 311 to length+311.
// - 625-line first-field blanking begins at line 624.
`timescale 1ns/10ps
`include "pav_consts.vh"
module pav_picture_adjust #(
   parameter DW = 10
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire in_valid,
   input wire [DW-1:0] in_luma,
   input wire [DW-1:0] in_raw,
   input wire [DW-1:0] in_cb,
   input wire [DW-1:0] in_cr,
   input wire [9:0] line_num,
   input wire [9:0] pixel_idx,
   output reg out_valid,
   output reg [DW-1:0] out_luma,
   output reg [DW-1:0] out_cb,
   output reg [DW-1:0] out_cr,
   output reg out_vbit,
   output reg out_blank
);
   reg [7:0] std_reg;
   reg [7:0] lgain_reg;
   reg [7:0] lofs_reg;
   reg [7:0] crot_reg;
   reg [7:0] cgain_reg;
   reg [7:0] blank_reg;
   wire [3:0] video_standard_sel = std_reg[3:0];
   wire standard_aux_bit = std_reg[`PAV_BIT_AUX];
   wire mono = std_reg[`PAV_BIT_MONO];
   wire setup_en = std_reg[`PAV_BIT_SETUP];
   wire [7:0] luma_gain_field = lgain_reg;
   wire [7:0] luma_offset_field = lofs_reg;
   wire [7:0] chroma_rotation_field = crot_reg;
   wire [7:0] chroma_gain_field = cgain_reg;
   wire blank_line_passthrough = blank_reg[`PAV_BIT_PASS];
   wire ref_code_vtiming_sel = blank_reg[`PAV_BIT_VSEL];
   wire half_line_pedestal = blank_reg[`PAV_BIT_HALF];
   wire [4:0] blank_length_field = blank_reg[4:0];
   wire is625 = (video_standard_sel & `PAV_STD_625) != 4'h0;
   wire is_comp = is625 || ((video_standard_sel & `PAV_STD_COMP) != 4'h0);

   // Clamp a signed wide result into the 10-bit sample range.
   function [DW-1:0] sat10;
      input signed [21:0] v;
      begin
         if (v < 0)
            sat10 = {DW{1'b0}};
         else if (v > $signed({12'h000, `PAV_MAX10}))
            sat10 = `PAV_MAX10;
         else
            sat10 = v[DW-1:0];
      end
   endfunction

   // Gain of 0x80 is unity: product shifted right by seven.
   function signed [21:0] gain7;
      input signed [21:0] s;
      input [7:0] g;
      reg signed [30:0] p;
      begin
         p = s * $signed({1'b0, g});
         gain7 = p[28:7];
      end
   endfunction

   // APB: zero wait states, unmapped reads give zero with pslverr.
   wire acc = psel && penable;
   reg hit;
   always @* begin
      case (paddr)
         `PAV_ADDR_STD, `PAV_ADDR_LGAIN, `PAV_ADDR_LOFS, `PAV_ADDR_CROT,
         `PAV_ADDR_CGAIN, `PAV_ADDR_BLANK, `PAV_ADDR_STAT: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         std_reg <= `PAV_RST_STD;
         lgain_reg <= `PAV_RST_LGAIN;
         lofs_reg <= `PAV_RST_LOFS;
         crot_reg <= `PAV_RST_CROT;
         cgain_reg <= `PAV_RST_CGAIN;
         blank_reg <= `PAV_RST_BLANK;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         prdata <= 32'h00000000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `PAV_ADDR_STD: prdata <= {24'h000000, std_reg};
               `PAV_ADDR_LGAIN: prdata <= {24'h000000, lgain_reg};
               `PAV_ADDR_LOFS: prdata <= {24'h000000, lofs_reg};
               `PAV_ADDR_CROT: prdata <= {24'h000000, crot_reg};
               `PAV_ADDR_CGAIN: prdata <= {24'h000000, cgain_reg};
               `PAV_ADDR_BLANK: prdata <= {24'h000000, blank_reg};
               `PAV_ADDR_STAT: prdata <= {30'h00000000, out_blank, out_vbit};
               default: prdata <= 32'h00000000;
            endcase
         end
         if (acc && pready && pwrite) begin
            case (paddr)
               `PAV_ADDR_STD: std_reg <= {1'b0, pwdata[6:0]};
               `PAV_ADDR_LGAIN: lgain_reg <= pwdata[7:0];
               `PAV_ADDR_LOFS: lofs_reg <= pwdata[7:0];
               `PAV_ADDR_CROT: crot_reg <= pwdata[7:0];
               `PAV_ADDR_CGAIN: cgain_reg <= pwdata[7:0];
               `PAV_ADDR_BLANK: blank_reg <= pwdata[7:0];
               default: std_reg <= std_reg;
            endcase
         end
      end
   end

   // Blanking interval and V-bit decode from the incoming line number.
   wire [9:0] len = {5'h00, blank_length_field};
   reg blank_now;
   reg vbit_now;
   reg first_f2;
   always @* begin
      if (is625) begin
         blank_now = (line_num <= len) || (line_num >= 10'd624) ||
            ((line_num >= 10'd311) && (line_num <= len + 10'd311));
         vbit_now = (line_num <= 10'd22) || (line_num >= 10'd624) ||
            ((line_num >= 10'd311) && (line_num <= 10'd335));
         first_f2 = (line_num == len + 10'd312);
      end else begin
         blank_now = (line_num <= len) ||
            ((line_num >= 10'd264) && (line_num <= len + 10'd245));
         if (ref_code_vtiming_sel)
            vbit_now = (line_num <= 10'd19) ||
               ((line_num >= 10'd264) && (line_num <= 10'd282));
         else
            vbit_now = (line_num <= 10'd9) ||
               ((line_num >= 10'd264) && (line_num <= 10'd272));
         first_f2 = (line_num == len + 10'd246);
      end
   end

   // Datapath: gain, offset, setup, then chroma rotation and gain.
   reg [DW-1:0] y_res;
   reg [DW-1:0] cb_res;
   reg [DW-1:0] cr_res;
   reg signed [21:0] yv;
   reg signed [21:0] cbv;
   reg signed [21:0] crv;
   reg signed [21:0] cbr;
   reg signed [21:0] crr;
   reg signed [21:0] hk;
   reg setup_apply;
   always @* begin
      yv = gain7($signed({12'h000, in_luma}), luma_gain_field);
      // Offset is applied in raw steps; scaling to output levels is upstream calibration.
      yv = yv + $signed({{14{luma_offset_field[7]}}, luma_offset_field});
      setup_apply = setup_en && !blank_now && (!first_f2 || !half_line_pedestal ||
         (pixel_idx >= `PAV_HALF_PIX));
      if (setup_apply)
         yv = yv + $signed({12'h000, `PAV_SETUP_OFS});
      y_res = sat10(yv);
      cbv = $signed({12'h000, in_cb}) - $signed({12'h000, `PAV_MID_C});
      crv = $signed({12'h000, in_cr}) - $signed({12'h000, `PAV_MID_C});
      // Small-angle rotation: sin ~ k, cos ~ 1, roughly 0.45 degree per step.
      hk = $signed({{14{chroma_rotation_field[7]}}, chroma_rotation_field});
      if (!is_comp) begin
         cbr = cbv - ((crv * hk) >>> 6'd7);
         crr = crv + ((cbv * hk) >>> 6'd7);
      end else begin
         cbr = cbv;
         crr = crv;
      end
      cb_res = sat10(gain7(cbr, chroma_gain_field) + $signed({12'h000, `PAV_MID_C}));
      cr_res = sat10(gain7(crr, chroma_gain_field) + $signed({12'h000, `PAV_MID_C}));
      if (mono) begin
         cb_res = `PAV_MID_C;
         cr_res = `PAV_MID_C;
      end
      if (blank_now) begin
         y_res = blank_line_passthrough ? in_raw : `PAV_BLACK_Y;
         cb_res = `PAV_MID_C;
         cr_res = `PAV_MID_C;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_luma <= `PAV_BLACK_Y;
         out_cb <= `PAV_MID_C;
         out_cr <= `PAV_MID_C;
         out_vbit <= 1'b1;
         out_blank <= 1'b1;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_luma <= y_res;
            out_cb <= cb_res;
            out_cr <= cr_res;
            out_vbit <= vbit_now;
            out_blank <= blank_now;
         end
      end
   end
endmodule // pav_picture_adjust

/* File: verification/pav_adj_chk.sv */
// Checker for pav_picture_adjust: bus handshake, blanking and reference code relations.
// Assumes it is bound to the design; register shadows follow completed writes.
`timescale 1ns/10ps
module pav_adj_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire in_valid,
   input wire [9:0] line_num,
   input wire out_valid,
   input wire [9:0] out_luma,
   input wire [9:0] out_cb,
   input wire [9:0] out_cr,
   input wire out_vbit,
   input wire out_blank
);
   reg [7:0] std_sh;
   reg [7:0] blk_sh;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         std_sh <= 8'h00;
         blk_sh <= 8'h14;
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == 12'h000) std_sh <= pwdata[7:0];
         if (paddr == 12'h014) blk_sh <= pwdata[7:0];
      end
   end
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_zero_wait: assert property (psel && !penable |=> pready) else $error("late ready");
   chk_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
   chk_valid_follows_in: assert property (in_valid |=> out_valid) else $error("valid lost");
   chk_valid_drops_idle: assert property (!in_valid |=> !out_valid) else $error("valid stuck");
   chk_err_read_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
      else $error("bad refused read");
   chk_mono_chroma: assert property (in_valid && std_sh[5] |=> out_cb == 10'h200 && out_cr == 10'h200)
      else $error("mono chroma not mid");
   chk_blank_chroma: assert property (out_valid && out_blank |-> out_cb == 10'h200)
      else $error("blank chroma not mid");
   chk_blank_black: assert property (out_valid && out_blank && !$past(blk_sh[7]) |-> out_luma == 10'h040)
      else $error("blank luma not black");
   chk_vbit_low_525: assert property (in_valid && !std_sh[3] && !blk_sh[6] && line_num >= 10'h00A
      && line_num < 10'h107 |=> !out_vbit) else $error("vbit high in active");
   chk_vbit_high_525: assert property (in_valid && !std_sh[3] && blk_sh[6] && line_num >= 10'h108
      && line_num <= 10'h11A |=> out_vbit) else $error("vbit low in blank");
   chk_vbit_high_625: assert property (in_valid && std_sh[3] && line_num >= 10'h137
      && line_num <= 10'h14F |=> out_vbit) else $error("vbit low 625");
   chk_blank_field2: assert property (in_valid && !std_sh[3] && line_num >= 10'h108
      && line_num <= {5'h00, blk_sh[4:0]} + 10'h0F5 |=> out_blank) else $error("no f2 blank");
   chk_blank_624: assert property (in_valid && std_sh[3] && line_num >= 10'h270 |=> out_blank)
      else $error("no blank at 624");
endmodule // pav_adj_chk
bind pav_picture_adjust pav_adj_chk u_chk (.*);

/* File: verification/pav_picture_adjust_test.sv */
// Self-checking bench for pav_picture_adjust: register access and picture stream tests.
// Assumes the source model feeds samples and the checker is bound to the design.
`timescale 1ns/10ps
module pav_picture_adjust_test;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg run = 1'b0;
   reg [9:0] ln = 10'h064;
   reg [9:0] y = 10'h100;
   reg [9:0] c = 10'h300;
   reg [31:0] rv;
   reg ev;
   wire [31:0] prdata;
   wire pready, pslverr, in_valid, out_valid, out_vbit, out_blank;
   wire [9:0] in_luma, in_raw, in_cb, in_cr, line_num, pixel_idx, out_luma, out_cb, out_cr;
   int err_total = 0;
   int check_count = 0;
   int i;
   always #4 pclk = ~pclk;
   pav_picture_adjust DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_valid(in_valid), .in_luma(in_luma), .in_raw(in_raw),
      .in_cb(in_cb), .in_cr(in_cr), .line_num(line_num), .pixel_idx(pixel_idx),
      .out_valid(out_valid), .out_luma(out_luma), .out_cb(out_cb), .out_cr(out_cr),
      .out_vbit(out_vbit), .out_blank(out_blank));
   pav_video_src u_src (.pclk(pclk), .presetn(presetn), .run(run), .line(ln), .y(y), .c(c),
      .in_valid(in_valid), .in_luma(in_luma), .in_raw(in_raw), .in_cb(in_cb), .in_cr(in_cr),
      .line_num(line_num), .pixel_idx(pixel_idx));
   task wrap_up;
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d, output [31:0] r, output e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40) err_total++;
   endtask
   task wr(input [11:0] a, input [31:0] d);
      apb(1'b1, a, d, rv, ev);
   endtask
   task rd(input [11:0] a, input [31:0] exp, input xe);
      apb(1'b0, a, 32'h0, rv, ev);
      cmp(rv, exp);
      cmp({31'h0, ev}, {31'h0, xe});
   endtask
   // Levels are held for several cycles so both pipeline stages settle before sampling.
   task px(input [9:0] l, input [9:0] yy, input [9:0] cc, input [9:0] ey, input [9:0] ec);
      ln <= l;
      y <= yy;
      c <= cc;
      repeat (4) @(posedge pclk);
      cmp({22'h0, out_luma}, {22'h0, ey});
      cmp({22'h0, out_cb}, {22'h0, ec});
   endtask
   task pv(input [9:0] l, input ev_exp, input eb);
      ln <= l;
      repeat (4) @(posedge pclk);
      cmp({31'h0, out_vbit}, {31'h0, ev_exp});
      cmp({31'h0, out_blank}, {31'h0, eb});
   endtask
   initial begin
      #50000;
      err_total++;
      wrap_up;
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      run <= 1'b1;
      for (i = 0; i < 6; i++)
         rd(12'(i * 4), (i == 1 || i == 4) ? 32'h80 : (i == 5) ? 32'h14 : 32'h0, 1'b0);
      rd(12'h01C, 32'h0, 1'b1);
      wr(12'h004, 32'hC3);
      rd(12'h004, 32'hC3, 1'b0);
      wr(12'h004, 32'hC0);
      px(10'h064, 10'h100, 10'h300, 10'h180, 10'h300);
      wr(12'h004, 32'hFF);
      px(10'h064, 10'h3F0, 10'h300, 10'h3FF, 10'h300);
      wr(12'h004, 32'h00);
      px(10'h064, 10'h3F0, 10'h300, 10'h000, 10'h300);
      wr(12'h004, 32'h80);
      wr(12'h008, 32'h7F);
      px(10'h064, 10'h100, 10'h300, 10'h17F, 10'h300);
      wr(12'h008, 32'h80);
      px(10'h064, 10'h040, 10'h300, 10'h000, 10'h300);
      wr(12'h008, 32'h00);
      wr(12'h010, 32'h40);
      px(10'h064, 10'h100, 10'h300, 10'h100, 10'h280);
      wr(12'h010, 32'hFF);
      px(10'h064, 10'h100, 10'h3F0, 10'h100, 10'h3FF);
      wr(12'h010, 32'h80);
      wr(12'h00C, 32'h40);
      for (i = 4; i <= 8; i += 4) begin
         wr(12'h000, 32'(i));
         px(10'h064, 10'h100, 10'h300, 10'h100, 10'h300);
      end
      wr(12'h00C, 32'h00);
      for (i = 0; i < 3; i++) begin
         wr(12'h000, 32'h20 + 32'(i * 4));
         px(10'h064, 10'h100, 10'h300, 10'h100, 10'h200);
      end
      wr(12'h000, 32'h00);
      px(10'h00F, 10'h100, 10'h300, 10'h040, 10'h200);
      wr(12'h014, 32'h94);
      for (i = 0; i < 2; i++) begin
         wr(12'h000, 32'(i * 16));
         px(10'h00F, 10'h100, 10'h300, 10'h055, 10'h200);
      end
      wr(12'h000, 32'h00);
      wr(12'h014, 32'h14);
      pv(10'h109, 1'b1, 1'b1);
      pv(10'h10A, 1'b1, 1'b0);
      pv(10'h009, 1'b1, 1'b1);
      pv(10'h00A, 1'b0, 1'b1);
      pv(10'h110, 1'b1, 1'b0);
      pv(10'h111, 1'b0, 1'b0);
      wr(12'h014, 32'h54);
      pv(10'h013, 1'b1, 1'b1);
      pv(10'h014, 1'b0, 1'b1);
      pv(10'h11A, 1'b1, 1'b0);
      pv(10'h11B, 1'b0, 1'b0);
      wr(12'h000, 32'h08);
      pv(10'h270, 1'b1, 1'b1);
      pv(10'h137, 1'b1, 1'b1);
      rd(12'h018, 32'h3, 1'b0);
      pv(10'h150, 1'b0, 1'b0);
      wrap_up;
   end
endmodule // pav_picture_adjust_test

/* File: verification/pav_video_src.sv */
// Upstream sample source model: steady samples on a chosen line while run is high.
// Assumes the bench sets line and levels; released data lines toggle every cycle.
`timescale 1ns/10ps
module pav_video_src (
   input wire pclk,
   input wire presetn,
   input wire run,
   input wire [9:0] line,
   input wire [9:0] y,
   input wire [9:0] c,
   output reg in_valid = 1'b0,
   output reg [9:0] in_luma = 10'h000,
   output reg [9:0] in_raw = 10'h000,
   output reg [9:0] in_cb = 10'h000,
   output reg [9:0] in_cr = 10'h000,
   output reg [9:0] line_num = 10'h000,
   output reg [9:0] pixel_idx = 10'h000
);
   // Idle data is inverted each cycle so a stale sample can never pass for a fresh one.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_valid <= 1'b0;
      end else begin
         in_valid <= run;
         line_num <= line;
         pixel_idx <= run ? pixel_idx + 10'h001 : 10'h000;
         in_luma <= run ? y : ~in_luma;
         in_raw <= run ? y ^ 10'h155 : ~in_raw;
         in_cb <= run ? c : ~in_cb;
         in_cr <= run ? 10'h000 - c : ~in_cr;
      end
   end
endmodule // pav_video_src
